// *** logic/srg_ctrl.sv ***
// SYSREF generator control: register bank and pulse sequencer.
// Assumes Avalon-MM master on sys_clk_in and an asynchronous request pin.
//
// How it works
// - Pre-divider code 2 divides by two, code 4 divides by four.
// - Burst mode in master mode: each request edge arriving while idle emits a pulse burst.
// - No SYSREF pulses unless generation enable is set.
// - Master mode without burst emits pulses continuously.
// - Repeater mode emits pulses only in answer to the request pin.
// - Output divider sets the pulse rate; it resets to one.
// - Four six-bit delay trims; first resets to 3F, others to zero.
// - Burst pulse count field sets pulses per request.
// - Request pin ignored while mask set and phase sync off.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "srg_defs.svh"
module srg_ctrl (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_n_in,
   input  wire srg_pkg::srg_avs_req_t avs_req_in,
   output logic [31:0]                avs_readdata_out,
   output logic                       avs_waitrequest_out,
   input  wire logic                  request_pin_in,
   output logic                       sysref_out,
   output srg_pkg::srg_trim_t         trim_out,
   output logic [4:0]                 channel_divider_select_out
);
   import srg_pkg::*;

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   function automatic logic [15:0] srg_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Unlisted codes pass through as their own ratio, zero as one
   function automatic logic [2:0] srg_prediv_ratio(input logic [2:0] code);
      logic [2:0] r;
      r = code;
      if (code == `SRG_PRE_DIV2) begin
         r = 3'h2;
      end else if (code == `SRG_PRE_DIV4) begin
         r = 3'h4;
      end else if (code == 3'h0) begin
         r = 3'h1;
      end
      return r;
   endfunction

   // -------------------------------------------------
   // Register bank and bus slave
   // -------------------------------------------------
   logic [15:0] mode_ff, rate_ff, trima_ff, trimb_ff, channel_divider_select_ff, pinctl_ff;
   logic [15:0] nxt_mode, nxt_rate, nxt_trima, nxt_trimb, nxt_channel_divider_select, nxt_pinctl;
   logic        ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        bus_req, bus_done;
   logic [6:0]  bus_idx;
   logic [15:0] rd_mux, status_w;

   srg_state_t  state_ff, nxt_state;
   logic [13:0] cnt_ff, nxt_cnt;
   logic [4:0]  remain_ff, nxt_remain;
   logic        pulse_ff, nxt_pulse;
   logic        req_level, req_rise;

   assign bus_req             = avs_req_in.read | avs_req_in.write;
   assign bus_idx             = avs_req_in.address[8:2];
   assign bus_done            = bus_req & ack_ff;
   // One wait state: data sampled on the edge that ends it
   assign avs_waitrequest_out = bus_req & ~ack_ff;
   assign status_w = {7'h00, req_level, remain_ff, state_ff};

   always_comb begin
      case (bus_idx)
         `SRG_IDX_MODE:   rd_mux = mode_ff;
         `SRG_IDX_RATE:   rd_mux = rate_ff;
         `SRG_IDX_TRIMA:  rd_mux = trima_ff;
         `SRG_IDX_TRIMB:  rd_mux = trimb_ff;
         `SRG_IDX_CHANNEL_DIVIDER_SELECT:  rd_mux = channel_divider_select_ff;
         `SRG_IDX_STATUS: rd_mux = status_w;
         `SRG_IDX_PINCTL: rd_mux = pinctl_ff;
         default:         rd_mux = 16'h0000;
      endcase
   end

   always_comb begin
      nxt_ack    = bus_req & ~ack_ff;
      nxt_rdata  = rdata_ff;
      nxt_mode   = mode_ff;
      nxt_rate   = rate_ff;
      nxt_trima  = trima_ff;
      nxt_trimb  = trimb_ff;
      nxt_channel_divider_select  = channel_divider_select_ff;
      nxt_pinctl = pinctl_ff;
      if (avs_req_in.read && !ack_ff) begin
         nxt_rdata = {16'h0000, rd_mux};
      end
      // Reserved bits are stored as written; software keeps them zero
      if (bus_done && avs_req_in.write) begin
         case (bus_idx)
            `SRG_IDX_MODE:   nxt_mode   = srg_merge(mode_ff, avs_req_in.writedata, avs_req_in.byteenable);
            `SRG_IDX_RATE:   nxt_rate   = srg_merge(rate_ff, avs_req_in.writedata, avs_req_in.byteenable);
            `SRG_IDX_TRIMA:  nxt_trima  = srg_merge(trima_ff, avs_req_in.writedata, avs_req_in.byteenable);
            `SRG_IDX_TRIMB:  nxt_trimb  = srg_merge(trimb_ff, avs_req_in.writedata, avs_req_in.byteenable);
            `SRG_IDX_CHANNEL_DIVIDER_SELECT:  nxt_channel_divider_select  = srg_merge(channel_divider_select_ff, avs_req_in.writedata, avs_req_in.byteenable);
            `SRG_IDX_PINCTL: nxt_pinctl = srg_merge(pinctl_ff, avs_req_in.writedata, avs_req_in.byteenable);
            default:         nxt_ack    = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_ff    <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         mode_ff   <= `SRG_RST_MODE;
         rate_ff   <= `SRG_RST_RATE;
         trima_ff  <= `SRG_RST_TRIMA;
         trimb_ff  <= `SRG_RST_TRIMB;
         channel_divider_select_ff  <= `SRG_RST_CHANNEL_DIVIDER_SELECT;
         pinctl_ff <= `SRG_RST_PINCTL;
      end else begin
         ack_ff    <= nxt_ack;
         rdata_ff  <= nxt_rdata;
         mode_ff   <= nxt_mode;
         rate_ff   <= nxt_rate;
         trima_ff  <= nxt_trima;
         trimb_ff  <= nxt_trimb;
         channel_divider_select_ff  <= nxt_channel_divider_select;
         pinctl_ff <= nxt_pinctl;
      end
   end

   assign avs_readdata_out           = rdata_ff;
   assign channel_divider_select_out = channel_divider_select_ff[`SRG_F_CHANNEL_DIVIDER_SELECT];
   assign trim_out.delay_trim_1      = trima_ff[`SRG_F_TRIM_LO];
   assign trim_out.delay_trim_2      = trima_ff[`SRG_F_TRIM_HI];
   assign trim_out.delay_trim_3      = trimb_ff[`SRG_F_TRIM_LO];
   assign trim_out.delay_trim_4      = trimb_ff[`SRG_F_TRIM_HI];

   // -------------------------------------------------
   // Request pin
   // -------------------------------------------------
   srg_req_sync u_req_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .pin_in     (request_pin_in),
      .level_out  (req_level),
      .rise_out   (req_rise)
   );

   // -------------------------------------------------
   // Pulse sequencer
   // -------------------------------------------------
   logic        gen_en, repeat_sel, burst_sel, pin_masked, req_take, tick;
   logic [2:0]  pre_ratio;
   logic [10:0] div_w;
   logic [13:0] period_w;
   logic [4:0]  burst_len;

   assign gen_en     = mode_ff[`SRG_B_EN];
   assign repeat_sel = mode_ff[`SRG_B_REPEAT];
   assign burst_sel  = mode_ff[`SRG_B_BURST];
   assign pin_masked = pinctl_ff[`SRG_B_MASK] & ~pinctl_ff[`SRG_B_PSYNC];
   assign pre_ratio  = srg_prediv_ratio(mode_ff[`SRG_F_PREDIV]);
   // A zero divider would stall the counter, so it acts as one
   assign div_w      = (rate_ff[`SRG_F_DIV] == 11'h000) ? 11'h001 : rate_ff[`SRG_F_DIV];
   assign period_w   = 14'(pre_ratio) * 14'(div_w);
   // Count of zero gives the longest burst rather than none
   assign burst_len  = (trimb_ff[`SRG_F_PCNT] == 4'h0) ? `SRG_BURST_MAX : {1'b0, trimb_ff[`SRG_F_PCNT]};
   assign req_take   = req_rise & ~pin_masked & gen_en & (repeat_sel | burst_sel);
   // Greater-or-equal guards against the period shrinking mid-count
   assign tick       = (cnt_ff + 14'h0001) >= period_w;

   always_comb begin
      nxt_state  = state_ff;
      nxt_remain = remain_ff;
      nxt_pulse  = 1'b0;
      nxt_cnt    = tick ? 14'h0000 : cnt_ff + 14'h0001;
      case (state_ff)
         srg_st_idle: begin
            nxt_cnt = 14'h0000;
            if (gen_en && !repeat_sel && !burst_sel) begin
               nxt_state = srg_st_run;
            end else if (req_take) begin
               nxt_state  = srg_st_burst;
               nxt_remain = repeat_sel ? 5'h01 : burst_len;
            end
         end
         srg_st_run: begin
            if (!gen_en || repeat_sel || burst_sel) begin
               nxt_state = srg_st_idle;
            end else if (tick) begin
               nxt_pulse = 1'b1;
            end
         end
         srg_st_burst: begin
            if (!gen_en) begin
               nxt_state  = srg_st_idle;
               nxt_remain = 5'h00;
            end else if (!repeat_sel && !burst_sel) begin
               // Switch to master mode mid-burst: go straight to continuous output
               nxt_state  = srg_st_run;
               nxt_remain = 5'h00;
            end else if (tick) begin
               nxt_pulse  = 1'b1;
               nxt_remain = remain_ff - 5'h01;
               if (remain_ff == 5'h01) begin
                  nxt_state = srg_st_idle;
               end
            end
         end
         default: begin
            nxt_state  = srg_st_idle;
            nxt_remain = 5'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff  <= srg_st_idle;
         cnt_ff    <= 14'h0000;
         remain_ff <= 5'h00;
         pulse_ff  <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         remain_ff <= nxt_remain;
         pulse_ff  <= nxt_pulse;
      end
   end

   assign sysref_out = pulse_ff;

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_burst_start;
      state_ff == srg_st_idle && req_take && !(gen_en && !repeat_sel && !burst_sel);
   endsequence

   property p_rate;
      (state_ff != srg_st_idle) |-> (nxt_pulse -> (cnt_ff + 14'h0001 >= period_w));
   endproperty
   a_rate: assert property (p_rate) else $error("pulse before divider period");

   property p_prediv;
      (mode_ff[`SRG_F_PREDIV] == `SRG_PRE_DIV4) |-> (period_w == {div_w, 2'b00} + 14'h0000);
   endproperty
   a_prediv: assert property (p_prediv) else $error("divide-by-four period wrong");

   property p_enable;
      (!gen_en) [*2] |-> !pulse_ff;
   endproperty
   a_enable: assert property (p_enable) else $error("pulse while generation disabled");

   property p_master;
      (gen_en && !repeat_sel && !burst_sel) [*2] |-> state_ff == srg_st_run;
   endproperty
   a_master: assert property (p_master) else $error("master mode not running");

   property p_repeater;
      (repeat_sel && state_ff != srg_st_burst) |-> !nxt_pulse;
   endproperty
   a_repeater: assert property (p_repeater) else $error("repeater pulse without request");

   property p_burst_load;
      s_burst_start |=> state_ff == srg_st_burst &&
                        remain_ff == ($past(repeat_sel) ? 5'h01 : $past(burst_len));
   endproperty
   a_burst_load: assert property (p_burst_load) else $error("burst length not loaded");

   property p_mask;
      pin_masked |-> !req_take;
   endproperty
   a_mask: assert property (p_mask) else $error("masked request accepted");

   property p_take_edge;
      req_take |-> req_rise ##1 !req_rise;
   endproperty
   a_take_edge: assert property (p_take_edge) else $error("request taken without edge");

   property p_rate_write;
      (bus_done && avs_req_in.write && bus_idx == `SRG_IDX_RATE && avs_req_in.byteenable[1:0] == 2'b11)
         |=> rate_ff == $past(avs_req_in.writedata[15:0]);
   endproperty
   a_rate_write: assert property (p_rate_write) else $error("divider write lost");

   property p_trim_write;
      (bus_done && avs_req_in.write && bus_idx == `SRG_IDX_TRIMA && avs_req_in.byteenable[0])
         |=> trim_out.delay_trim_1 == $past(avs_req_in.writedata[5:0]);
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim write lost");

   property p_wait_one;
      (bus_req && avs_waitrequest_out) |=> (bus_req -> !avs_waitrequest_out);
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

   property p_prediv2;
      (mode_ff[`SRG_F_PREDIV] == `SRG_PRE_DIV2) |-> (period_w == {2'b00, div_w, 1'b0});
   endproperty
   a_prediv2: assert property (p_prediv2) else $error("divide-by-two period wrong");

   property p_idle_quiet;
      (state_ff == srg_st_idle) |-> !nxt_pulse;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("pulse from idle state");

   property p_burst_step;
      (state_ff == srg_st_burst && gen_en && (repeat_sel || burst_sel) && tick)
         |=> remain_ff == $past(remain_ff) - 5'h01;
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst count not stepped");

   property p_burst_end;
      (state_ff == srg_st_burst && nxt_pulse && remain_ff == 5'h01) |=> state_ff == srg_st_idle;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst ran past its count");

   property p_read_mode;
      (avs_req_in.read && !ack_ff && bus_idx == `SRG_IDX_MODE)
         |=> avs_readdata_out == {16'h0000, $past(mode_ff)};
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("mode read back wrong");

   property p_disabled_idle;
      (!gen_en) [*2] |-> state_ff == srg_st_idle;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("sequencer active while disabled");

endmodule
`default_nettype wire

// *** logic/srg_defs.svh ***
// Constants for the SYSREF generator control block.
// Assumes register indices are word indices; byte address is index times four.
`ifndef SRG_DEFS_SVH
`define SRG_DEFS_SVH

// -------------------------------------------------
// Register indices
// -------------------------------------------------
`define SRG_IDX_MODE    7'h47
`define SRG_IDX_RATE    7'h48
`define SRG_IDX_TRIMA   7'h49
`define SRG_IDX_TRIMB   7'h4A
`define SRG_IDX_CHANNEL_DIVIDER_SELECT   7'h4B
`define SRG_IDX_STATUS  7'h60
`define SRG_IDX_PINCTL  7'h61

// -------------------------------------------------
// Reset values
// -------------------------------------------------
`define SRG_RST_MODE    16'h0080
`define SRG_RST_RATE    16'h0001
`define SRG_RST_TRIMA   16'h003F
`define SRG_RST_TRIMB   16'h0000
`define SRG_RST_CHANNEL_DIVIDER_SELECT   16'h0800
`define SRG_RST_PINCTL  16'h8000

// -------------------------------------------------
// Field positions
// -------------------------------------------------
`define SRG_F_PREDIV    7:5
`define SRG_B_BURST     4
`define SRG_B_EN        3
`define SRG_B_REPEAT    2
`define SRG_F_DIV       10:0
`define SRG_F_TRIM_HI   11:6
`define SRG_F_TRIM_LO   5:0
`define SRG_F_PCNT      15:12
`define SRG_F_CHANNEL_DIVIDER_SELECT     10:6
`define SRG_B_MASK      15
`define SRG_B_PSYNC     0

// -------------------------------------------------
// Decode constants
// -------------------------------------------------
`define SRG_PRE_DIV2    3'h2
`define SRG_PRE_DIV4    3'h4
`define SRG_BURST_MAX   5'h10

`endif

// *** logic/srg_pkg.sv ***
// Types shared by the SYSREF generator control block.
// Assumes Avalon-MM with a 9-bit byte address and 32-bit data.
package srg_pkg;

   // -------------------------------------------------
   // Bus request bundle
   // -------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [8:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } srg_avs_req_t;

   // -------------------------------------------------
   // Delay trim outputs
   // -------------------------------------------------
   typedef struct packed {
      logic [5:0] delay_trim_4;
      logic [5:0] delay_trim_3;
      logic [5:0] delay_trim_2;
      logic [5:0] delay_trim_1;
   } srg_trim_t;

   typedef enum logic [2:0] {
      srg_st_idle  = 3'h1,
      srg_st_run   = 3'h2,
      srg_st_burst = 3'h4
   } srg_state_t;

endpackage

// *** logic/srg_req_sync.sv ***
// Request pin synchroniser with rising edge detect.
// Assumes the pin is asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module srg_req_sync (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      rise_out
);
   logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
   logic nxt_lvl, nxt_rise;

   // Level changes only once stages two and three agree
   always_comb begin
      nxt_lvl  = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
      nxt_rise = nxt_lvl & ~lvl_ff;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_ff   <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         lvl_ff  <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         s1_ff   <= pin_in;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         lvl_ff  <= nxt_lvl;
         rise_ff <= nxt_rise;
      end
   end

   assign level_out = lvl_ff;
   assign rise_out  = rise_ff;

   property p_rise_single;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rise_ff |=> !rise_ff;
   endproperty
   a_rise_single: assert property (p_rise_single) else $error("request edge longer than one cycle");
endmodule
`default_nettype wire

// *** dv/srg_conv_model.sv ***
// Far-side model: a data converter that counts SYSREF pulses.
// Assumes sysref_in is a one-cycle pulse on sys_clk_in; also drives the request pin.
`timescale 1ns/1ps
`default_nettype none
module srg_conv_model (
   input  wire logic sys_clk_in,
   input  wire logic req_cmd_in,
   input  wire logic clr_in,
   input  wire logic sysref_in,
   output logic      request_pin_out,
   output int        pulse_cnt_out,
   output int        gap_out
);
   int since;

   // -------------------------------------------------
   // Request pin and pulse bookkeeping
   // -------------------------------------------------
   // Pin launched from a flop so it never moves on the sampling edge
   always_ff @(posedge sys_clk_in) begin
      request_pin_out <= req_cmd_in;
      if (clr_in) begin
         pulse_cnt_out <= 0;
         gap_out       <= 0;
         since         <= 0;
      end else if (sysref_in !== 1'b0) begin
         pulse_cnt_out <= pulse_cnt_out + 1;
         gap_out       <= since + 1;
         since         <= 0;
      end else begin
         since <= since + 1;
      end
   end
endmodule
`default_nettype wire

// *** dv/srg_ctrl_tb.sv ***
// Self-checking bench for the SYSREF generator control block.
// Assumes the far-side model in srg_conv_model; bus waits are taken as they come.
`timescale 1ns/1ps
`default_nettype none
`include "srg_defs.svh"
module srg_ctrl_tb;
   import srg_pkg::*;
   logic         sys_clk;
   logic         rst_n;
   srg_avs_req_t avs_req;
   logic [31:0]  rdata;
   logic         waitreq;
   logic         req_pin;
   logic         sysref;
   srg_trim_t    trim;
   logic [4:0]   chsel;
   logic         req_cmd;
   logic         clr;
   int           pcnt;
   int           gap;
   int           err_count;
   int           n_checks;
   logic [31:0]  rd;

   srg_ctrl dut (
      .sys_clk_in                 (sys_clk),
      .rst_n_in                   (rst_n),
      .avs_req_in                 (avs_req),
      .avs_readdata_out           (rdata),
      .avs_waitrequest_out        (waitreq),
      .request_pin_in             (req_pin),
      .sysref_out                 (sysref),
      .trim_out                   (trim),
      .channel_divider_select_out (chsel)
   );

   srg_conv_model conv (
      .sys_clk_in      (sys_clk),
      .req_cmd_in      (req_cmd),
      .clr_in          (clr),
      .sysref_in       (sysref),
      .request_pin_out (req_pin),
      .pulse_cnt_out   (pcnt),
      .gap_out         (gap)
   );

   // -------------------------------------------------
   // Shared tasks
   // -------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Held until waitrequest is seen low at a rising edge; data taken at that edge
   task automatic bus(input logic rd_en, input logic [6:0] idx, input logic [15:0] wd);
      @(posedge sys_clk);
      avs_req <= '{rd_en, !rd_en, {idx, 2'b00}, 4'h3, {16'h0000, wd}};
      do begin
         @(posedge sys_clk);
      end while (waitreq !== 1'b0);
      rd = rdata;
      avs_req <= '0;
   endtask

   task automatic wr(input logic [6:0] idx, input logic [15:0] wd);
      bus(1'b0, idx, wd);
   endtask

   task automatic rdc(input logic [6:0] idx, input logic [31:0] exp, input string what);
      bus(1'b1, idx, 16'h0000);
      chk(rd, exp, what);
   endtask

   // Clears the pulse count, optionally raises the pin, then counts pulses
   task automatic window(input logic do_req, input int cyc, input int exp, input string what);
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      req_cmd <= do_req;
      repeat (30) @(posedge sys_clk);
      req_cmd <= 1'b0;
      repeat (cyc) @(posedge sys_clk);
      chk(pcnt, exp, what);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // -------------------------------------------------
   // Clock, reset, watchdog
   // -------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Whole sequence is well under 3000 cycles
   initial begin
      #100000;
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end

   // -------------------------------------------------
   // Tests
   // -------------------------------------------------
   initial begin
      err_count = 0;
      n_checks  = 0;
      avs_req   = '0;
      req_cmd   = 1'b0;
      clr       = 1'b0;
      rst_n     = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;

      rdc(`SRG_IDX_MODE, 32'h0000_0080, "mode reset");
      rdc(`SRG_IDX_RATE, 32'h0000_0001, "divider reset");
      rdc(`SRG_IDX_TRIMA, 32'h0000_003F, "trim a reset");
      rdc(`SRG_IDX_TRIMB, 32'h0000_0000, "trim b reset");
      rdc(`SRG_IDX_CHANNEL_DIVIDER_SELECT, 32'h0000_0800, "channel_divider_select reset");
      rdc(`SRG_IDX_PINCTL, 32'h0000_8000, "pin ctl reset");
      rdc(`SRG_IDX_STATUS, 32'h0000_0001, "status reset");
      chk({8'h00, trim}, {8'h00, 6'h00, 6'h00, 6'h00, 6'h3F}, "trim out reset");
      rdc(7'h10, 32'h0000_0000, "unmapped read");
      window(1'b1, 60, 0, "disabled stays quiet");
      $display("TEST reset done");

      wr(`SRG_IDX_TRIMA, 16'h0ABC);
      wr(`SRG_IDX_TRIMB, 16'h0F55);
      wr(`SRG_IDX_CHANNEL_DIVIDER_SELECT, 16'h0A40);
      rdc(`SRG_IDX_TRIMA, 32'h0000_0ABC, "trim a rw");
      rdc(`SRG_IDX_TRIMB, 32'h0000_0F55, "trim b rw");
      chk({8'h00, trim}, {8'h00, 6'h3D, 6'h15, 6'h2A, 6'h3C}, "trim out");
      chk({27'h0, chsel}, 32'h0000_0009, "channel_divider_select out");
      wr(`SRG_IDX_TRIMB, 16'h0000);
      $display("TEST registers done");

      wr(`SRG_IDX_RATE, 16'h0003);
      rdc(`SRG_IDX_RATE, 32'h0000_0003, "divider rw");
      wr(`SRG_IDX_MODE, 16'h0048);
      rdc(`SRG_IDX_STATUS, 32'h0000_0002, "status run");
      repeat (40) @(posedge sys_clk);
      chk(gap, 32'd6, "period prediv 2");
      wr(`SRG_IDX_MODE, 16'h0088);
      repeat (60) @(posedge sys_clk);
      chk(gap, 32'd12, "period prediv 4");
      wr(`SRG_IDX_MODE, 16'h0008);
      repeat (30) @(posedge sys_clk);
      chk(gap, 32'd3, "period prediv 0");
      wr(`SRG_IDX_MODE, 16'h0080);
      window(1'b0, 40, 0, "stops when disabled");
      $display("TEST master done");

      wr(`SRG_IDX_PINCTL, 16'h0000);
      wr(`SRG_IDX_MODE, 16'h004C);
      window(1'b0, 40, 0, "repeater idle");
      window(1'b1, 40, 1, "repeater one pulse");
      wr(`SRG_IDX_MODE, 16'h0040);
      repeat (20) @(posedge sys_clk);
      $display("TEST repeater done");

      wr(`SRG_IDX_TRIMB, 16'h3000);
      wr(`SRG_IDX_MODE, 16'h0058);
      window(1'b1, 60, 3, "burst of three");
      wr(`SRG_IDX_TRIMB, 16'h5000);
      window(1'b1, 60, 5, "burst of five");
      wr(`SRG_IDX_PINCTL, 16'h8000);
      window(1'b1, 60, 0, "masked request");
      wr(`SRG_IDX_PINCTL, 16'h8001);
      window(1'b1, 60, 5, "mask with phase sync");
      $display("TEST burst done");

      stop_test();
   end
endmodule
`default_nettype wire
